//--- design/isr_start_ctrl.sv
// How it works
// - Reservations enabled: start during busy bus after a detected start is held, fired by a shift write after the stop.
// - Start request on idle bus after stop: generate start, then wait.
// - Pending reservation: shift write after stop starts master; earlier writes ignored.
// - Start request: released bus gives start, busy bus gives reservation if reservations are enabled and a start was detected.
// - Reservation accepted only between start detection and stop detection.
// - Reservations disabled: start during busy bus is rejected, no start made.
// - Start result flag valid within five clocks of the request.
// - Bus unused by us after arbitration loss or release after extension code.
// - Without start-without-stop, enabling sets bus busy; stop needed first.
// - With start-without-stop, enabling clears bus busy; software checks bus free.
// - Enabling with data low and clock high is taken as a start.
// - Arbitration loss sets the loss flag and releases both lines.
// - Stop detection raises interrupt only when stop interrupt enable is set.
module isr_start_ctrl
#(
    parameter int WIDTH_BITS = isr_pkg::WIDTH_BITS
)
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire isr_pkg::isr_ctrl_t CTRL,
    input wire logic START_REQUEST,
    input wire logic STOP_REQUEST,
    input wire logic SHIFT_WRITE,
    input wire logic ARB_LOST,
    input wire logic [WIDTH_BITS-1:0] LOW_WIDTH,
    input wire logic [WIDTH_BITS-1:0] HIGH_WIDTH,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic START_PENDING,
    output logic STOP_PENDING,
    output logic RESERVED,
    output logic WAIT_STATE,
    output isr_pkg::isr_stat_t STATUS,
    output logic SERIAL_INTERRUPT_REQUEST
);
    logic scl_s;
    logic sda_s;
    logic start_pulse;
    logic stop_pulse;
    logic enable_prev_reg;
    logic enable_rise;
    logic start_req_reg;
    logic stop_req_reg;
    logic resolve;
    logic busy_now;
    logic [WIDTH_BITS:0] gen_cnt_reg;
    logic sda_drive_reg;
    logic scl_drive_reg;
    logic int_reg;
    isr_pkg::isr_state_t state_reg;
    isr_pkg::isr_stat_t stat_reg;
    logic busy_reg, start_det_reg, stop_det_reg, result_reg, master_reg, ald_reg;
    localparam int RESULT_CLKS = isr_pkg::START_RESULT_CLKS;

    isr_line_mon u_mon
    (
        .clk(MCLK),
        .rst_n(RST_N),
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .start_pulse(start_pulse),
        .stop_pulse(stop_pulse)
    );

    assign enable_rise = CTRL.interface_enable && !enable_prev_reg;
    // Each status bit has its own flop, several sharing one process; the struct only gathers them.
    assign stat_reg = {master_reg, start_det_reg, stop_det_reg, busy_reg, result_reg, ald_reg};
    assign busy_now = stat_reg.bus_busy_status && !stop_pulse;
    // Request is resolved on the cycle after it is latched.
    assign resolve = start_req_reg && (state_reg == isr_pkg::ISR_IDLE);

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            enable_prev_reg <= 1'b0;
        end
        else
        begin
            enable_prev_reg <= CTRL.interface_enable;
        end
    end

    // Start request bit clears itself once resolved.
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            start_req_reg <= 1'b0;
            stop_req_reg <= 1'b0;
        end
        else if (!CTRL.interface_enable)
        begin
            start_req_reg <= 1'b0;
            stop_req_reg <= 1'b0;
        end
        else
        begin
            if (START_REQUEST && !start_req_reg && !stop_req_reg)
            begin
                start_req_reg <= 1'b1;
            end
            else if (resolve)
            begin
                start_req_reg <= 1'b0;
            end
            if (STOP_REQUEST && !start_req_reg && !stop_req_reg)
            begin
                stop_req_reg <= 1'b1;
            end
            else if (stop_req_reg && stop_pulse)
            begin
                stop_req_reg <= 1'b0;
            end
        end
    end

    // Bus busy tracking.
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            busy_reg <= 1'b0;
            start_det_reg <= 1'b0;
            stop_det_reg <= 1'b0;
        end
        else if (!CTRL.interface_enable)
        begin
            busy_reg <= 1'b0;
            start_det_reg <= 1'b0;
            stop_det_reg <= 1'b0;
        end
        else if (enable_rise)
        begin
            busy_reg <= !CTRL.start_without_stop_enable;
            // Low data under high clock at enable counts as a start.
            start_det_reg <= scl_s && !sda_s;
            stop_det_reg <= 1'b0;
        end
        else if (start_pulse)
        begin
            busy_reg <= 1'b1;
            start_det_reg <= 1'b1;
            stop_det_reg <= 1'b0;
        end
        else if (stop_pulse)
        begin
            busy_reg <= 1'b0;
            start_det_reg <= 1'b0;
            stop_det_reg <= 1'b1;
        end
    end

    // Start resolution, reservation and deferred master launch.
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_reg <= isr_pkg::ISR_IDLE;
            result_reg <= 1'b0;
            master_reg <= 1'b0;
            gen_cnt_reg <= '0;
        end
        else if (!CTRL.interface_enable || ARB_LOST || CTRL.bus_release)
        begin
            // Arbitration loss or release leaves us neither master nor slave.
            state_reg <= isr_pkg::ISR_IDLE;
            master_reg <= 1'b0;
            gen_cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                isr_pkg::ISR_IDLE:
                begin
                    if (resolve && !busy_now)
                    begin
                        state_reg <= isr_pkg::ISR_START;
                        result_reg <= 1'b1;
                        master_reg <= 1'b1;
                        gen_cnt_reg <= '0;
                    end
                    else if (resolve && !CTRL.reservation_disable && stat_reg.start_detected)
                    begin
                        state_reg <= isr_pkg::ISR_RESERVED;
                        result_reg <= 1'b0;
                    end
                    else if (resolve)
                    begin
                        result_reg <= 1'b0;
                    end
                end
                isr_pkg::ISR_RESERVED:
                begin
                    // Shift writes before the stop are discarded.
                    if (stat_reg.stop_detected && !stat_reg.bus_busy_status && SHIFT_WRITE)
                    begin
                        state_reg <= isr_pkg::ISR_START;
                        master_reg <= 1'b1;
                        result_reg <= 1'b1;
                        gen_cnt_reg <= '0;
                    end
                end
                isr_pkg::ISR_START:
                begin
                    // Data held low for the low width plus the start hold count before clock pulled low.
                    if (gen_cnt_reg >= {1'b0, LOW_WIDTH} + (WIDTH_BITS+1)'(isr_pkg::START_HOLD_CLKS))
                    begin
                        state_reg <= isr_pkg::ISR_WAIT;
                    end
                    else
                    begin
                        gen_cnt_reg <= gen_cnt_reg + (WIDTH_BITS+1)'(1);
                    end
                end
                isr_pkg::ISR_WAIT:
                begin
                    if (SHIFT_WRITE)
                    begin
                        state_reg <= isr_pkg::ISR_MASTER;
                    end
                end
                isr_pkg::ISR_MASTER:
                begin
                    if (stop_pulse)
                    begin
                        state_reg <= isr_pkg::ISR_IDLE;
                        master_reg <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= isr_pkg::ISR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ald_reg <= 1'b0;
        end
        else if (ARB_LOST)
        begin
            ald_reg <= 1'b1;
        end
        else if (resolve)
        begin
            ald_reg <= 1'b0;
        end
    end

    // Line drivers: release both lines on arbitration loss.
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sda_drive_reg <= 1'b0;
            scl_drive_reg <= 1'b0;
        end
        else if (ARB_LOST || !CTRL.interface_enable)
        begin
            sda_drive_reg <= 1'b0;
            scl_drive_reg <= 1'b0;
        end
        else
        begin
            sda_drive_reg <= (state_reg == isr_pkg::ISR_START) || (state_reg == isr_pkg::ISR_WAIT);
            scl_drive_reg <= (state_reg == isr_pkg::ISR_WAIT);
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            int_reg <= 1'b0;
        end
        else
        begin
            int_reg <= stop_pulse && CTRL.stop_interrupt_enable && CTRL.interface_enable;
        end
    end

    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE = scl_drive_reg;
    assign SDA_OE = sda_drive_reg;
    assign START_PENDING = start_req_reg;
    assign STOP_PENDING = stop_req_reg;
    // One-hot state: each flag is the state flop's own bit.
    assign RESERVED = state_reg[1];
    assign WAIT_STATE = state_reg[3];
    assign STATUS = stat_reg;
    assign SERIAL_INTERRUPT_REQUEST = int_reg;

    resolve_time_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        $rose(start_req_reg) |-> ##[1:RESULT_CLKS] !start_req_reg)
        else $error("Start request not resolved in time.");
    reject_nostart_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (resolve && busy_now && CTRL.reservation_disable) |=> state_reg == isr_pkg::ISR_IDLE
        && !stat_reg.start_result_flag)
        else $error("Rejected request made a start.");
    reserve_take_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (resolve && busy_now && !CTRL.reservation_disable && stat_reg.start_detected && !ARB_LOST
        && !CTRL.bus_release) |=> RESERVED)
        else $error("Reservation not recorded.");
    idle_start_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (resolve && !busy_now && !ARB_LOST && !CTRL.bus_release && CTRL.interface_enable)
        |=> state_reg == isr_pkg::ISR_START && stat_reg.master_status)
        else $error("Idle bus start not generated.");
    early_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RESERVED && !stat_reg.stop_detected) |=> !stat_reg.master_status)
        else $error("Early shift write started master.");
    enable_busy_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        enable_rise |=> stat_reg.bus_busy_status == !$past(CTRL.start_without_stop_enable))
        else $error("Bus busy wrong after enable.");
    stop_irq_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        SERIAL_INTERRUPT_REQUEST |-> $past(CTRL.stop_interrupt_enable) && $past(stop_pulse))
        else $error("Interrupt without stop enable.");
    arb_release_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        ARB_LOST |=> !SDA_OE && !SCL_OE && stat_reg.arbitration_loss_flag)
        else $error("Lines not released on arbitration loss.");
    reserve_window_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        $rose(RESERVED) |-> $past(stat_reg.start_detected))
        else $error("Reservation outside window.");

    start_c: cover property (@(posedge MCLK) disable iff (!RST_N) $rose(WAIT_STATE));
    reserve_c: cover property (@(posedge MCLK) disable iff (!RST_N) $rose(RESERVED));
    launch_c: cover property (@(posedge MCLK) disable iff (!RST_N) RESERVED ##1 !RESERVED && stat_reg.master_status);
endmodule : isr_start_ctrl

//--- inc/isr_pkg.sv
package isr_pkg;
    // Start resolution latency: result flag valid within this many clocks.
    localparam int START_RESULT_CLKS = 5;
    // Sync stages for pins.
    localparam int SYNC_STAGES = 2;
    // Width of the clock width settings.
    localparam int WIDTH_BITS = 8;
    // Start hold count in clocks.
    localparam int START_HOLD_CLKS = 4;
    // Enable-to-release window for joining an active bus.
    localparam int JOIN_MIN_CLKS = 4;
    localparam int JOIN_MAX_CLKS = 80;

    typedef enum logic [4:0] {
        ISR_IDLE = 5'h01,
        ISR_RESERVED = 5'h02,
        ISR_START = 5'h04,
        ISR_WAIT = 5'h08,
        ISR_MASTER = 5'h10
    } isr_state_t;

    typedef struct packed {
        logic interface_enable;
        logic reservation_disable;
        logic start_without_stop_enable;
        logic stop_interrupt_enable;
        logic bus_release;
    } isr_ctrl_t;

    typedef struct packed {
        logic master_status;
        logic start_detected;
        logic stop_detected;
        logic bus_busy_status;
        logic start_result_flag;
        logic arbitration_loss_flag;
    } isr_stat_t;
endpackage : isr_pkg

//--- design/isr_line_mon.sv
// Samples both bus lines on the block clock and reports start and stop conditions.
module isr_line_mon
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_s,
    output logic sda_s,
    output logic start_pulse,
    output logic stop_pulse
);
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    // Data falling while clock high is a start, rising while clock high a stop.
    assign start_pulse = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign stop_pulse = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
endmodule : isr_line_mon

//--- sim/isr_bus_peer.sv
// Another party on the two-wire bus, driving open-drain lines from its own 80 ns link clock.
// Both lines are pulled up, so a released line reads high; the link clock stands high outside frames.
module isr_bus_peer
(
    output logic scl_oe,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    task automatic data_low();
        sda_oe = 1'b1;
    endtask : data_low

    // Start condition followed by two clock pulses of a frame.
    task automatic start_cond();
        sda_oe = 1'b1;
        #40;
        scl_oe = 1'b1;
        repeat (2)
        begin
            #40;
            scl_oe = 1'b0;
            #40;
            scl_oe = 1'b1;
        end
        #40;
    endtask : start_cond

    // Stop condition: data rises while the clock is high, then both lines stay released.
    task automatic stop_cond();
        scl_oe = 1'b1;
        sda_oe = 1'b1;
        #40;
        scl_oe = 1'b0;
        #40;
        sda_oe = 1'b0;
        #40;
    endtask : stop_cond
endmodule : isr_bus_peer

//--- sim/tb_isr_start_ctrl.sv
module tb_isr_start_ctrl;
    timeunit 1ns;
    timeprecision 100ps;

    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    isr_pkg::isr_ctrl_t CTRL = '0;
    logic START_REQUEST = 1'b0;
    logic STOP_REQUEST = 1'b0;
    logic SHIFT_WRITE = 1'b0;
    logic ARB_LOST = 1'b0;
    logic [7:0] LOW_WIDTH = 8'h04;
    logic [7:0] HIGH_WIDTH = 8'h04;
    logic scl_line;
    logic sda_line;
    logic SCL_OUT, SCL_OE, SDA_OUT, SDA_OE;
    logic START_PENDING, STOP_PENDING, RESERVED, WAIT_STATE, SERIAL_INTERRUPT_REQUEST;
    isr_pkg::isr_stat_t STATUS;
    logic peer_scl_oe, peer_sda_oe;
    int errors = 0;
    int num_checks = 0;
    int irq_count = 0;
    int irq_base = 0;

    // Wired-AND with pull-ups: any enabled driver pulls the line low.
    assign scl_line = ~(SCL_OE | peer_scl_oe);
    assign sda_line = ~(SDA_OE | peer_sda_oe);

    always #5 MCLK = ~MCLK;

    always @(posedge MCLK)
        if (SERIAL_INTERRUPT_REQUEST === 1'b1)
            irq_count++;

    isr_start_ctrl #(.WIDTH_BITS(8)) uut
    (
        .MCLK(MCLK), .RST_N(RST_N), .CTRL(CTRL), .START_REQUEST(START_REQUEST),
        .STOP_REQUEST(STOP_REQUEST), .SHIFT_WRITE(SHIFT_WRITE), .ARB_LOST(ARB_LOST),
        .LOW_WIDTH(LOW_WIDTH), .HIGH_WIDTH(HIGH_WIDTH), .SCL_IN(scl_line), .SDA_IN(sda_line),
        .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
        .START_PENDING(START_PENDING), .STOP_PENDING(STOP_PENDING), .RESERVED(RESERVED),
        .WAIT_STATE(WAIT_STATE), .STATUS(STATUS), .SERIAL_INTERRUPT_REQUEST(SERIAL_INTERRUPT_REQUEST)
    );

    isr_bus_peer peer
    (
        .scl_oe(peer_scl_oe),
        .sda_oe(peer_sda_oe)
    );

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : wait_cyc

    // Control bits in struct order: enable, no-reservation, start-without-stop, stop irq, release.
    task automatic set_ctrl(input logic [4:0] v);
        @(posedge MCLK);
        CTRL <= isr_pkg::isr_ctrl_t'(v);
        wait_cyc(2);
    endtask : set_ctrl

    // One-cycle request, then the five clocks the result flag needs to settle.
    task automatic req_start();
        @(posedge MCLK);
        START_REQUEST <= 1'b1;
        @(posedge MCLK);
        START_REQUEST <= 1'b0;
        wait_cyc(5);
    endtask : req_start

    task automatic shift_wr();
        @(posedge MCLK);
        SHIFT_WRITE <= 1'b1;
        @(posedge MCLK);
        SHIFT_WRITE <= 1'b0;
        wait_cyc(2);
    endtask : shift_wr

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    initial
    begin
        #200us;
        errors++;
        test_done();
    end

    initial
    begin
        repeat (5) @(posedge MCLK);
        RST_N <= 1'b1;
        wait_cyc(1);
        chk("status after reset", 8'h00, 8'(STATUS));
        chk("outputs after reset", 8'h00, {SCL_OUT, SDA_OUT, SCL_OE, SDA_OE, START_PENDING, RESERVED});
        set_ctrl(5'b10010);
        chk("busy at enable", 8'h01, 8'(STATUS.bus_busy_status));
        req_start();
        chk("start on busy bus", 8'h00, {START_PENDING, STATUS.master_status, RESERVED, SDA_OE});
        @(posedge MCLK);
        STOP_REQUEST <= 1'b1;
        @(posedge MCLK);
        STOP_REQUEST <= 1'b0;
        wait_cyc(2);
        chk("stop pending", 8'h01, 8'(STOP_PENDING));
        req_start();
        chk("start while stop pending", 8'h00, {START_PENDING, STATUS.master_status});
        irq_base = irq_count;
        peer.stop_cond();
        wait_cyc(8);
        chk("stop seen", 8'h04, {STATUS.stop_detected, STATUS.bus_busy_status, STOP_PENDING});
        chk("stop irq enabled", 8'h01, 8'(irq_count - irq_base));
        wait_cyc(72);
        req_start();
        chk("idle start result", 8'h03, {START_PENDING, STATUS.master_status, STATUS.start_result_flag});
        for (int i = 0; i < 20 && WAIT_STATE !== 1'b1; i++)
            wait_cyc(1);
        wait_cyc(1);
        chk("wait after start", 8'h07, {WAIT_STATE, SCL_OE, SDA_OE});
        shift_wr();
        chk("wait left", 8'h00, 8'(WAIT_STATE));
        @(posedge MCLK);
        ARB_LOST <= 1'b1;
        @(posedge MCLK);
        ARB_LOST <= 1'b0;
        wait_cyc(2);
        chk("arb loss", 8'h04, {STATUS.master_status, STATUS.arbitration_loss_flag, SCL_OE, SDA_OE});
        peer.start_cond();
        wait_cyc(4);
        chk("start detected", 8'h01, 8'(STATUS.start_detected));
        req_start();
        wait_cyc(9);
        chk("reservation", 8'h02, {RESERVED, STATUS.master_status});
        shift_wr();
        wait_cyc(8);
        chk("early shift write", 8'h02, {RESERVED, SDA_OE});
        irq_base = irq_count;
        peer.stop_cond();
        wait_cyc(8);
        chk("reserved stop irq", 8'h01, 8'(irq_count - irq_base));
        shift_wr();
        for (int i = 0; i < 20 && SDA_OE !== 1'b1; i++)
            wait_cyc(1);
        chk("reserved start", 8'h05, {SDA_OE, RESERVED, STATUS.master_status});
        set_ctrl(5'b10011);
        set_ctrl(5'b10010);
        chk("release to idle", 8'h00, {STATUS.master_status, WAIT_STATE, SCL_OE, SDA_OE});
        set_ctrl(5'b11000);
        peer.start_cond();
        wait_cyc(4);
        req_start();
        chk("start rejected", 8'h00, {STATUS.start_result_flag, RESERVED, STATUS.master_status, SDA_OE});
        irq_base = irq_count;
        peer.stop_cond();
        wait_cyc(8);
        chk("stop no irq", 8'h10, {STATUS.stop_detected, 4'(irq_count - irq_base)});
        set_ctrl(5'b00000);
        set_ctrl(5'b10100);
        chk("free at enable", 8'h00, 8'(STATUS.bus_busy_status));
        // Data goes low before the disable so that only the level at enable can flag the start.
        peer.data_low();
        set_ctrl(5'b00000);
        set_ctrl(5'b10000);
        chk("enable on low data", 8'h01, 8'(STATUS.start_detected));
        wait_cyc(2);
        set_ctrl(5'b10001);
        chk("join release", 8'h00, {RESERVED, WAIT_STATE, STATUS.master_status, SDA_OE});
        peer.stop_cond();
        wait_cyc(8);
        test_done();
    end
endmodule : tb_isr_start_ctrl
